// File: dv/mbaik_partner.sv
// Purpose: Far-side model: arbiter and acknowledging slave
// Assumes: Grant follows request one cycle later
// Notes:   Gives rtyCnt retries, then ackCode, after ackDly+1 data cycles
`timescale 1ns/1ps
module mbaik_partner
   import mbaik_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // Master activity
   input  wire logic       busReqN,
   input  wire logic       asNOe,
   input  wire logic       madOe,
   // Scenario controls
   input  wire logic [2:0] ackCode,
   input  wire logic [2:0] rtyCode,
   input  wire logic [3:0] rtyCnt,
   input  wire logic [3:0] ackDly,
   // Grant and acknowledge pins
   output logic            grantN,
   output logic            errN,
   output logic            pRdyN,
   output logic            rtyN
);
   logic [3:0] waitCnt;
   logic [3:0] rtyDone;
   ////////////////////////////////////////////////////////////
   // Grant and one acknowledge per data phase, idle code otherwise
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         grantN <= 1'b1;
         {errN, pRdyN, rtyN} <= ACK_IDLE;
         waitCnt <= 4'h0;
         rtyDone <= 4'h0;
      end else begin
         grantN <= busReqN;
         {errN, pRdyN, rtyN} <= ACK_IDLE;
         waitCnt <= 4'h0;
         if (madOe && !asNOe && {errN, pRdyN, rtyN} == ACK_IDLE) begin
            waitCnt <= waitCnt + 4'h1;
            if (waitCnt == ackDly) begin
               if (rtyDone < rtyCnt) begin
                  {errN, pRdyN, rtyN} <= rtyCode;
                  rtyDone <= rtyDone + 4'h1;
               end else begin
                  {errN, pRdyN, rtyN} <= ackCode;
                  rtyDone <= 4'h0;
               end
            end
         end
      end
   end
endmodule

// File: dv/mbus_ack_irq_snoop_tb.sv
// Purpose: Self-checking bench for mbaik_core
// Assumes: Partner model answers every bus transfer
// Notes:   Register reads checked through an expectation queue
`timescale 1ns/1ps
module mbus_ack_irq_snoop_tb
   import mbaik_pkg::*;
;
   logic        clk_sys = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [3:0]  regAddr = 4'h0, irqLevel = 4'h0, moduleId, ackDly = 4'h0, rtyCnt = 4'h0;
   logic [31:0] regWdata = 32'h0, regRdata, expAddr = 32'h0, expCmd = 32'h0;
   logic [7:0]  rtyTot = 8'h0;
   logic        irq, rdyNIn, rdyNOut, rdyNOe, errN, rtyN, pRdyN, asNIn, asNOut, asNOe, madOe;
   logic [63:0] madOut;
   logic        busReqN, grantN, busyNIn, busyNOut, busyNOe, otherBusyN = 1'b1;
   logic        write_outstanding_in = 1'b1, controller_attach_select = 1'b1, takeInterrupt;
   logic [3:0]  takenLevel;
   logic        snoopOwned = 1'b0, snoopHeld = 1'b0, inhibitNOut, inhibitNOe, inhibitNIn;
   logic        sharedNOut, sharedNOe, sharedNIn, rdSeen = 1'b0, prevBlock = 1'b1;
   logic [2:0]  ackCode = ACK_VALID, rtyCode = ACK_RETRY;
   logic [31:0] expQ[$], mskQ[$];
   int          miscompares = 0, cmp_count = 0, cycles = 0, strobes = 0;
   // Open-drain and shared wires resolved from all drivers
   assign asNIn = asNOut | ~asNOe;
   assign busyNIn = (busyNOut | ~busyNOe) & otherBusyN;
   assign rdyNIn = pRdyN & (rdyNOut | ~rdyNOe);
   assign inhibitNIn = inhibitNOut | ~inhibitNOe;
   assign sharedNIn = sharedNOut | ~sharedNOe;
   mbaik_core dut_u (.clk_sys, .reset_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq,
      .errN, .rdyNIn, .rdyNOut, .rdyNOe, .rtyN, .madIn(64'h0), .madOut, .madOe, .asNIn, .asNOut,
      .asNOe, .busReqN, .grantN, .busyNIn, .busyNOut, .busyNOe, .irqLevel, .moduleId,
      .write_outstanding_in, .controller_attach_select, .takeInterrupt, .takenLevel, .snoopOwned,
      .snoopHeld, .inhibitNOut, .inhibitNOe, .inhibitNIn, .sharedNOut, .sharedNOe, .sharedNIn);
   mbaik_partner partner_u (.clk_sys, .reset_n, .busReqN, .asNOe, .madOe, .ackCode, .rtyCode,
      .rtyCnt, .ackDly, .grantN, .errN, .pRdyN, .rtyN);
   // Clock at 250 MHz
   initial forever #2 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
      expQ.push_back(e & m);
      mskQ.push_back(m);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
   endtask
   // One GO transfer: n retries, then code; check status and ack info
   task automatic xfer(input logic [2:0] code, input logic [3:0] n);
      logic [31:0] st;
      int i;
      ackCode <= code;
      rtyCnt <= n;
      ackDly <= 4'($urandom_range(3));
      rtyCode <= $urandom_range(1) ? ACK_RETRY : ACK_RELRETRY;
      write_outstanding_in <= 1'($urandom);
      expAddr = $urandom;
      strobes = 0;
      wr(REG_ADDR, expAddr);
      expCmd = $urandom;
      wr(REG_CMD, expCmd);
      wr(REG_CTRL, 32'h1);
      for (i = 0; i < 400 && !(strobes == n + 1 && !madOe); i++)
         @(negedge clk_sys);
      repeat (2) @(posedge clk_sys);
      st = (code == ACK_VALID) ? 32'h1 : 32'h2;
      st[EV_RETRY] = (n != 4'h0);
      check(32'(strobes), 32'(n) + 32'h1, "strobe count");
      rd(REG_STATUS, st, 32'h7);
      rtyTot = rtyTot + 8'(n);
      rd(REG_ACKINFO, {rtyTot, 10'h0, controller_attach_select, ~write_outstanding_in, moduleId, 6'h0,
         2'(3'h4 - {1'b0, code[1:0]})}, (code == ACK_VALID) ? 32'hff003f00 : 32'hff003f03);
      @(negedge clk_sys);
      check({31'h0, irq}, 32'h1, "irq raised");
      wr(REG_CLEAR, 32'h3f);
      repeat (2) @(negedge clk_sys);
      check({31'h0, irq}, 32'h0, "irq cleared");
      @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////
   // Reads, command strobes and timeout checked as they appear
   always @(posedge clk_sys) begin
      rdSeen <= regRd;
      prevBlock <= grantN | ~busyNIn;
      if (rdSeen)
         check(regRdata & mskQ.pop_front(), expQ.pop_front(), "read");
      if (asNOe) begin
         strobes++;
         check({30'h0, asNOut, prevBlock}, 32'h0, "start");
         check(madOut[31:0], expAddr, "cmd addr");
      end
      if (madOe && !asNOe)
         check(madOut[31:0], expCmd, "data word");
      if (madOe)
         check({29'h0, busyNOe, busyNOut, rdyNOe}, 32'h4, "bus drive");
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   // Main sequence
   initial begin
      logic [3:0] lvl, pil;
      logic ten;
      int i;
      void'($urandom(15));
      moduleId = 4'($urandom);
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      wr(4'hc, 32'hffffffff);
      rd(REG_STATUS, 32'h0, 32'hffffffff);
      rd(REG_ENABLE, 32'h0, 32'hffffffff);
      rd(4'h8, 32'h0, 32'hffffffff);
      wr(REG_ENABLE, 32'h3f);
      rd(REG_ENABLE, 32'h3f, 32'h3f);
      $display("Test reset and registers done");
      xfer(ACK_VALID, 4'h0);
      otherBusyN <= 1'b0;
      fork
         xfer(ACK_VALID, 4'h2);
         begin
            repeat (20) @(posedge clk_sys);
            otherBusyN <= 1'b1;
         end
      join
      for (i = 1; i < 4; i++)
         xfer(3'(i), 4'(i - 1));
      $display("Test transfers done");
      for (i = 0; i < 28; i++) begin
         lvl = (i < 16) ? 4'(i) : 4'($urandom);
         pil = 4'(lvl - 4'(i % 2));
         ten = (i % 4) > 1;
         wr(REG_CTRL, {24'h0, pil, 2'h0, ten, 1'b0});
         irqLevel <= lvl;
         repeat (2) @(negedge clk_sys);
         check({31'h0, takeInterrupt}, {31'h0, lvl == IRL_NMI || (ten && lvl != IRL_NONE && lvl > pil)},
            "take");
         check({28'h0, takenLevel}, {28'h0, lvl}, "level");
         @(posedge clk_sys);
         irqLevel <= IRL_NONE;
      end
      rd(REG_STATUS, 32'h18, 32'h18);
      wr(REG_ENABLE, 32'h0);
      repeat (2) @(negedge clk_sys);
      check({31'h0, irq}, 32'h0, "irq masked");
      wr(REG_ENABLE, 32'h3f);
      repeat (2) @(negedge clk_sys);
      check({31'h0, irq}, 32'h1, "irq unmasked");
      wr(REG_CLEAR, 32'h3f);
      repeat (2) @(negedge clk_sys);
      check({31'h0, irq}, 32'h0, "irq cleared");
      $display("Test interrupts done");
      for (i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         snoopOwned <= i[0];
         snoopHeld <= i[1];
         repeat (2) @(negedge clk_sys);
         check({28'h0, inhibitNOe, inhibitNOut, sharedNOe, sharedNOut},
            {28'h0, i[0], 1'b0, i[1], 1'b0}, "snoop");
      end
      $display("Test snoop done");
      complete_run();
   end
endmodule

// File: hdl/mbaik_ack_decode.sv
// Purpose: Decode the three-wire acknowledge into one-hot classes
// Assumes: Pins sampled synchronous to clk_sys
// Notes:   Purely combinational
`timescale 1ns/1ps
module mbaik_ack_decode
   import mbaik_pkg::*;
(
   // Acknowledge pins, active low
   input  wire logic errN,
   input  wire logic rdyN,
   input  wire logic rtyN,
   // Decoded classes
   output logic      isIdle,
   output logic      isRetry,
   output logic      isValid,
   output logic      isError,
   output logic      isResv,
   output logic [1:0] errClass
);
   logic [2:0] code;
   // Classify code
   always_comb begin
      code     = {errN, rdyN, rtyN};
      isIdle   = (code == ACK_IDLE);
      isRetry  = (code == ACK_RELRETRY) || (code == ACK_RETRY);
      isValid  = (code == ACK_VALID);
      isResv   = (code == ACK_RESV);
      isError  = (code == ACK_BUSERR) || (code == ACK_TIMEOUT) || (code == ACK_UNCORR);
      errClass = isError ? (2'h0 - code[1:0]) : 2'h0; // 1 bus, 2 timeout, 3 uncorrectable
   end
endmodule

// File: hdl/mbaik_core.sv
// Purpose: Bus master acknowledge handling, interrupt level intake and snoop responses
// Assumes: All pins synchronous to clk_sys; open-drain pins as in/out/enable triples
// Notes:   One single-beat write transaction per GO; retries reissue it unchanged
// Overview of operation
// - Decode idle, relinquish-retry, valid data acknowledges
// - Low error line gives error classes or retry
// - Level zero means no interrupt pending
// - Level fifteen is nonmaskable, ignores trap disable
// - Levels one to fourteen maskable, fourteen highest
// - Owned block snooped: assert memory inhibit
// - Held block snooped: assert shared low
// - Address strobe low exactly with address word
// - Request bus; start only granted and free
`timescale 1ns/1ps
module mbaik_core
   import mbaik_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Register port
   input  wire logic [3:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [31:0]      regRdata,
   output logic             irq,
   // Acknowledge pins
   input  wire logic        errN,
   input  wire logic        rdyNIn,
   output logic             rdyNOut,
   output logic             rdyNOe,
   input  wire logic        rtyN,
   // Command/data lines
   input  wire logic [63:0] madIn,
   output logic [63:0]      madOut,
   output logic             madOe,
   input  wire logic        asNIn,
   output logic             asNOut,
   output logic             asNOe,
   // Arbitration
   output logic             busReqN,
   input  wire logic        grantN,
   input  wire logic        busyNIn,
   output logic             busyNOut,
   output logic             busyNOe,
   // Interrupt and identity
   input  wire logic [3:0]  irqLevel,
   input  wire logic [3:0]  moduleId,
   input  wire logic        write_outstanding_in,
   input  wire logic        controller_attach_select,
   output logic             takeInterrupt,
   output logic [3:0]       takenLevel,
   // Snoop hooks from cache tags
   input  wire logic        snoopOwned,
   input  wire logic        snoopHeld,
   output logic             inhibitNOut,
   output logic             inhibitNOe,
   input  wire logic        inhibitNIn,
   output logic             sharedNOut,
   output logic             sharedNOe,
   input  wire logic        sharedNIn
);
   typedef struct packed {
      mbaik_state_e    st;
      logic [63:0]     addr;
      logic [63:0]     cmd;
      logic            go;
      logic            trapEn;
      logic [3:0]      pil;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] enable;
      logic [1:0]      lastErr;
      logic [7:0]      retries;
      logic [7:0]      backoff;
      logic            inh;
      logic            shr;
      logic            take;
      logic [3:0]      lvl;
      logic [31:0]     rdata;
   } mbaik_state_s;

   mbaik_state_s cur_ff, nxt_cur;
   logic isIdle, isRetry, isValid, isError, isResv;
   logic [1:0] errClass;
   logic [EV_W-1:0] evSet;

   ////////////////////////////////////////////////////////////////////////////////
   // Acknowledge decoder
   mbaik_ack_decode uDec (
      .errN     (errN),
      .rdyN     (rdyNIn),
      .rtyN     (rtyN),
      .isIdle   (isIdle),
      .isRetry  (isRetry),
      .isValid  (isValid),
      .isError  (isError),
      .isResv   (isResv),
      .errClass (errClass)
   );

   // Level interpretation: zero none, fifteen nonmaskable, else above processor level
   function automatic logic irqWins(input logic [3:0] lvl, input logic en, input logic [3:0] pil);
      irqWins = (lvl == IRL_NMI) || (en && (lvl != IRL_NONE) && (lvl > pil));
   endfunction

   // Register read mux
   function automatic logic [31:0] rdMux(input logic [3:0] a, input mbaik_state_s s,
                                         input logic [3:0] mid, input logic wp, input logic ca);
      case (a)
         REG_CTRL:    rdMux = {24'h0, s.pil, 2'h0, s.trapEn, s.go};
         REG_STATUS:  rdMux = {26'h0, s.status};
         REG_ENABLE:  rdMux = {26'h0, s.enable};
         REG_ADDR:    rdMux = s.addr[31:0];
         REG_CMD:     rdMux = s.cmd[31:0];
         REG_ACKINFO: rdMux = {s.retries, 8'h0, 2'h0, ca, ~wp, mid, 6'h0, s.lastErr};
         REG_SNOOP:   rdMux = {28'h0, ~sharedNIn, ~inhibitNIn, s.shr, s.inh};
         default:     rdMux = 32'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      nxt_cur = cur_ff;
      evSet   = '0;
      nxt_cur.rdata = regRd ? rdMux(regAddr, cur_ff, moduleId, write_outstanding_in,
                                    controller_attach_select) : 32'h0;
      // Software writes
      if (regWr) begin
         case (regAddr)
            REG_CTRL: begin
               if (regWdata[CTRL_GO] && cur_ff.st == MBAIK_IDLE) begin
                  nxt_cur.go = 1'b1;
               end
               nxt_cur.trapEn = regWdata[CTRL_TRAPEN];
               nxt_cur.pil    = regWdata[CTRL_PIL_LO +: 4];
            end
            REG_ENABLE: nxt_cur.enable = regWdata[EV_W-1:0];
            REG_CLEAR:  nxt_cur.status = cur_ff.status & ~regWdata[EV_W-1:0];
            REG_ADDR:   nxt_cur.addr = {32'h0, regWdata};
            REG_CMD:    nxt_cur.cmd  = {32'h0, regWdata};
            default: begin
            end
         endcase
      end
      // Interrupt intake
      nxt_cur.take = irqWins(irqLevel, cur_ff.trapEn, cur_ff.pil);
      nxt_cur.lvl  = irqLevel;
      if (irqLevel == IRL_NMI) begin
         evSet[EV_NMI] = 1'b1;
      end else if (irqWins(irqLevel, cur_ff.trapEn, cur_ff.pil)) begin
         evSet[EV_IRQ] = 1'b1;
      end
      // Snoop responses, one cycle after the hit
      nxt_cur.inh = snoopOwned;
      nxt_cur.shr = snoopHeld;
      // Master sequence
      case (cur_ff.st)
         MBAIK_IDLE: begin
            if (cur_ff.go) begin
               nxt_cur.st = MBAIK_REQ;
            end
         end
         MBAIK_REQ: begin
            if (!grantN && busyNIn) begin
               nxt_cur.st = MBAIK_CMD;
            end
         end
         MBAIK_CMD: nxt_cur.st = MBAIK_DATA;
         MBAIK_DATA: begin
            if (isValid) begin
               nxt_cur.st = MBAIK_IDLE;
               nxt_cur.go = 1'b0;
               evSet[EV_DONE] = 1'b1;
            end else if (isRetry) begin
               nxt_cur.st      = MBAIK_WAIT;
               nxt_cur.backoff = 8'(BACKOFF_CYC);
               nxt_cur.retries = cur_ff.retries + 8'h1;
               evSet[EV_RETRY] = 1'b1;
            end else if (isError) begin
               nxt_cur.st      = MBAIK_IDLE;
               nxt_cur.go      = 1'b0;
               nxt_cur.lastErr = errClass;
               evSet[EV_ERROR] = 1'b1;
            end else if (isResv) begin
               evSet[EV_RESV] = 1'b1;
            end
         end
         MBAIK_WAIT: begin
            if (cur_ff.backoff <= 8'h1) begin
               nxt_cur.st = MBAIK_REQ;
            end else begin
               nxt_cur.backoff = cur_ff.backoff - 8'h1;
            end
         end
         default: nxt_cur.st = MBAIK_IDLE;
      endcase
      // Set wins over clear
      nxt_cur.status = nxt_cur.status | evSet;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cur_ff <= '{st: MBAIK_IDLE, pil: PIL_RST, status: EV_RST, enable: EV_RST, default: '0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign regRdata      = cur_ff.rdata;
   assign irq           = |(cur_ff.status & cur_ff.enable);
   assign takeInterrupt = cur_ff.take;
   assign takenLevel    = cur_ff.lvl;
   assign busReqN       = !(cur_ff.st == MBAIK_REQ);
   assign asNOut        = 1'b0;
   assign asNOe         = (cur_ff.st == MBAIK_CMD);
   assign madOe         = (cur_ff.st == MBAIK_CMD) || (cur_ff.st == MBAIK_DATA);
   assign madOut        = (cur_ff.st == MBAIK_CMD) ? cur_ff.addr : cur_ff.cmd;
   assign busyNOut      = 1'b0;
   assign busyNOe       = (cur_ff.st == MBAIK_CMD) || (cur_ff.st == MBAIK_DATA);
   assign rdyNOut       = 1'b1;
   assign rdyNOe        = 1'b0;
   assign inhibitNOut   = 1'b0;
   assign inhibitNOe    = cur_ff.inh;
   assign sharedNOut    = 1'b0;
   assign sharedNOe     = cur_ff.shr;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_cmdPhase;
      asNOe ##1 (cur_ff.st == MBAIK_DATA);
   endsequence

   // Top level always taken
   property p_nmi;
      @(posedge clk_sys) disable iff (!reset_n) (irqLevel == IRL_NMI) |=> takeInterrupt;
   endproperty
   a_nmi: assert property (p_nmi) else $error("NMI not taken");

   // Level zero never taken
   property p_zero;
      @(posedge clk_sys) disable iff (!reset_n) (irqLevel == IRL_NONE) |=> !takeInterrupt;
   endproperty
   a_zero: assert property (p_zero) else $error("Level zero taken");

   // Trap disable blocks maskable levels
   property p_mask;
      @(posedge clk_sys) disable iff (!reset_n)
         (irqLevel != IRL_NMI && !cur_ff.trapEn) |=> !takeInterrupt;
   endproperty
   a_mask: assert property (p_mask) else $error("Masked level taken");

   // Command only after grant with bus free
   property p_start;
      @(posedge clk_sys) disable iff (!reset_n)
         $rose(asNOe) |-> $past(!grantN && busyNIn && cur_ff.st == MBAIK_REQ);
   endproperty
   a_start: assert property (p_start) else $error("Start without grant");

   // Strobe lasts the command cycle only
   property p_as;
      @(posedge clk_sys) disable iff (!reset_n) asNOe |-> s_cmdPhase;
   endproperty
   a_as: assert property (p_as) else $error("Strobe not one cycle");

   // Retry releases the bus, then requests again
   property p_retry;
      @(posedge clk_sys) disable iff (!reset_n)
         (cur_ff.st == MBAIK_DATA && isRetry) |=> (busyNOe == 1'b0) ##[1:20] !busReqN;
   endproperty
   a_retry: assert property (p_retry) else $error("Retry not reissued");

   // Owned hit drives inhibit
   property p_inh;
      @(posedge clk_sys) disable iff (!reset_n) snoopOwned |=> inhibitNOe;
   endproperty
   a_inh: assert property (p_inh) else $error("Inhibit missing");

   // Held hit drives shared
   property p_shr;
      @(posedge clk_sys) disable iff (!reset_n) snoopHeld |=> sharedNOe;
   endproperty
   a_shr: assert property (p_shr) else $error("Shared missing");

   // Error acknowledge recorded with its class
   property p_err;
      @(posedge clk_sys) disable iff (!reset_n)
         (cur_ff.st == MBAIK_DATA && isError) |=> cur_ff.status[EV_ERROR] && cur_ff.lastErr != 2'h0;
   endproperty
   a_err: assert property (p_err) else $error("Error not recorded");

   // Valid data ends the transfer
   property p_done;
      @(posedge clk_sys) disable iff (!reset_n)
         (cur_ff.st == MBAIK_DATA && isValid) |=> cur_ff.status[EV_DONE] && !busyNOe;
   endproperty
   a_done: assert property (p_done) else $error("Valid ack not handled");

   // Request stands until granted and free
   property p_reqHold;
      @(posedge clk_sys) disable iff (!reset_n) (!busReqN && (grantN || !busyNIn)) |=> !busReqN;
   endproperty
   a_reqHold: assert property (p_reqHold) else $error("Request dropped early");

   // Idle acknowledge keeps the data phase open
   property p_idleAck;
      @(posedge clk_sys) disable iff (!reset_n) (cur_ff.st == MBAIK_DATA && isIdle) |=> (cur_ff.st == MBAIK_DATA);
   endproperty
   a_idleAck: assert property (p_idleAck) else $error("Idle ack ended phase");

   // Bus error reported as class one
   property p_errClass;
      @(posedge clk_sys) disable iff (!reset_n)
         (cur_ff.st == MBAIK_DATA && {errN, rdyNIn, rtyN} == ACK_BUSERR) |=> (cur_ff.lastErr == 2'h1);
   endproperty
   a_errClass: assert property (p_errClass) else $error("Bus error class wrong");

   // Reported level follows the pins
   property p_level;
      @(posedge clk_sys) disable iff (!reset_n) reset_n |=> (takenLevel == $past(irqLevel));
   endproperty
   a_level: assert property (p_level) else $error("Level not reported");

   // Enabled level above processor level taken
   property p_maskable;
      @(posedge clk_sys) disable iff (!reset_n)
         (irqLevel != IRL_NONE && cur_ff.trapEn && irqLevel > cur_ff.pil) |=> takeInterrupt;
   endproperty
   a_maskable: assert property (p_maskable) else $error("Maskable level not taken");

   // No inhibit without an owned hit
   property p_noInh;
      @(posedge clk_sys) disable iff (!reset_n) !snoopOwned |=> !inhibitNOe;
   endproperty
   a_noInh: assert property (p_noInh) else $error("Stray inhibit");

   // No shared without a held hit
   property p_noShr;
      @(posedge clk_sys) disable iff (!reset_n) !snoopHeld |=> !sharedNOe;
   endproperty
   a_noShr: assert property (p_noShr) else $error("Stray shared");
endmodule

// File: hdl/mbaik_pkg.sv
// Purpose: Shared constants and types for the bus acknowledge, interrupt and snoop block
// Assumes: Single clock clk_sys at 250 MHz, synchronous active-low reset
// Notes:   Register offsets are word indices on the plain register port
package mbaik_pkg;
   // Acknowledge codes {err, rdy, rty}, all pins active low
   localparam logic [2:0] ACK_IDLE     = 3'h7;
   localparam logic [2:0] ACK_RELRETRY = 3'h6;
   localparam logic [2:0] ACK_VALID    = 3'h5;
   localparam logic [2:0] ACK_RESV     = 3'h4;
   localparam logic [2:0] ACK_BUSERR   = 3'h3;
   localparam logic [2:0] ACK_TIMEOUT  = 3'h2;
   localparam logic [2:0] ACK_UNCORR   = 3'h1;
   localparam logic [2:0] ACK_RETRY    = 3'h0;
   // Interrupt levels
   localparam logic [3:0] IRL_NONE = 4'h0;
   localparam logic [3:0] IRL_NMI  = 4'hf;
   // Register offsets
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_STATUS  = 4'h1;
   localparam logic [3:0] REG_ENABLE  = 4'h2;
   localparam logic [3:0] REG_CLEAR   = 4'h3;
   localparam logic [3:0] REG_ADDR    = 4'h4;
   localparam logic [3:0] REG_CMD     = 4'h5;
   localparam logic [3:0] REG_ACKINFO = 4'h6;
   localparam logic [3:0] REG_SNOOP   = 4'h7;
   // Control register fields
   localparam int CTRL_GO     = 0;
   localparam int CTRL_TRAPEN = 1;
   localparam int CTRL_PIL_LO = 4;
   // Status / enable / clear bit positions
   localparam int EV_DONE  = 0;
   localparam int EV_ERROR = 1;
   localparam int EV_RETRY = 2;
   localparam int EV_IRQ   = 3;
   localparam int EV_NMI   = 4;
   localparam int EV_RESV  = 5;
   localparam int EV_W     = 6;
   // Reset values
   localparam logic [3:0]      PIL_RST  = 4'h0;
   localparam logic [EV_W-1:0] EV_RST   = 6'h00;
   // Retry back-off time and count at 250 MHz
   localparam int CLK_MHZ      = 250;
   localparam int BACKOFF_NS   = 40;
   localparam int BACKOFF_CYC  = (BACKOFF_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [2:0] {MBAIK_IDLE, MBAIK_REQ, MBAIK_CMD, MBAIK_DATA, MBAIK_WAIT} mbaik_state_e;
endpackage
